// >>> rtl/bspc_page_buffer.sv
// Temporary page buffer with registered read data
`timescale 1ns/1ps
module bspc_page_buffer #(
   parameter int DEPTH = 128,
   parameter int WIDTH = 16
) (
   input  wire logic                     clock,   // System clock
   input  wire logic                     wrEn,    // Write strobe
   input  wire logic [$clog2(DEPTH)-1:0] wrIdx,   // Write word index
   input  wire logic [WIDTH-1:0]         wrData,  // Write data
   input  wire logic [$clog2(DEPTH)-1:0] rdIdx,   // Read word index
   output logic      [WIDTH-1:0]         rdData   // Read data, one cycle later
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Refuse a shape the index logic cannot serve
   if (DEPTH < 2 || WIDTH < 1) $error("page buffer shape not supported");

   // One write port, one registered read port
   always_ff @(posedge clock) begin
      if (wrEn) begin
         mem[wrIdx] <= wrData;
      end
      rdData <= mem[rdIdx];
   end
endmodule

// >>> rtl/bspc_pkg.sv
// Shared constants for the boot self-program controller
package bspc_pkg;
   localparam logic [7:0]  CSR_ADDR       = 8'h37;   // Control and status register offset
   localparam logic [7:0]  CSR_RESET      = 8'h00;   // Value after reset
   localparam int          BIT_IE         = 7;       // Ready interrupt enable
   localparam int          BIT_BUSY       = 6;       // Section busy flag
   localparam int          BIT_SIG        = 5;       // Signature read command
   localparam int          BIT_REEN       = 4;       // Section read re-enable
   localparam int          BIT_LOCK       = 3;       // Lock bit set command
   localparam int          BIT_PGWR       = 2;       // Page write command
   localparam int          BIT_PGER       = 1;       // Page erase command
   localparam int          BIT_EN         = 0;       // Store enable
   localparam logic [4:0]  PAT_REEN       = 5'h11;   // 10001
   localparam logic [4:0]  PAT_LOCK       = 5'h09;   // 01001
   localparam logic [4:0]  PAT_PGWR       = 5'h05;   // 00101
   localparam logic [4:0]  PAT_PGER       = 5'h03;   // 00011
   localparam logic [4:0]  PAT_FILL       = 5'h01;   // 00001
   localparam int          STORE_WINDOW   = 4;       // Cycles a store may follow the write
   localparam int          LOAD_WINDOW    = 3;       // Cycles a load may follow the write
   localparam int          PC_W           = 16;      // Program counter width
   localparam int          PTR_W          = 17;      // Pointer width
   localparam int          WORD_IDX_W     = 7;       // Word index within a page
   localparam int          PAGE_W         = 9;       // Page number width
   localparam int          PAGE_WORDS     = 128;     // Words per page
   localparam logic [8:0]  HALT_PAGE      = 9'h1E0;  // First halting page, word 0xF000
   localparam logic [16:0] FLASH_TOP      = 17'h10000; // One past the last word
   localparam logic [15:0] BOOT_MIN_WORDS = 16'h0200;  // Boot section size for code 11
   localparam logic [15:0] ERASED_WORD    = 16'hFFFF;  // Buffer word after discard
   typedef enum logic [1:0] {
      BSPC_IDLE  = 2'b00,
      BSPC_ARMED = 2'b01,
      BSPC_BUSY  = 2'b11
   } bspc_state_type;
endpackage

// >>> rtl/bspc_top.sv
// Boot self-program controller: control register, command windows, page buffer
`timescale 1ns/1ps
//
// What this block does
// [R1] Boot size code picks top boot section
// [R2] Words below 0xF000 readable-while-write, rest halting
// [R3] Sixteen-bit counter, 128-word pages, seven-bit index
// [R4] Erase/write page from pointer bits 16:8
// [R5] Fill word from pointer 7:1; zero on write
// [R6] Pointer bit 0 zero on store; load byte select
// [R7] Ready irq when enable, global, store clear
// [R8] Busy flag set on region program; blocks reads
// [R9] Busy cleared by re-enable or buffer fill
// [R10] Signature read: load returns row, store ignored
// [R11] Re-enable store unblocks region, not while busy
// [R12] Re-enable during fill discards buffer
// [R13] Lock set store programs lock from low data
// [R14] Load in lock window returns lock or fuse
// [R15] Page write store programs buffer into page
// [R16] Page erase store erases pointer page
// [R17] Halt CPU during halting-region erase or write
// [R18] Plain store fills buffer word with data pair
// [R19] Store enable clears on done or timeout
// [R20] Other low-five patterns ignored
// [R21] CPU keeps one store active at once
// [R22] Windows counted from cycle after write
//
module bspc_top
   import bspc_pkg::*;
(
   input  wire logic             clock,          // 100 MHz system clock
   input  wire logic             rst,            // Synchronous reset, active high
   input  wire logic [7:0]       regAddr,        // Register address
   input  wire logic [7:0]       regWrData,      // Register write data
   input  wire logic             regWr,          // Register write strobe
   input  wire logic             regRd,          // Register read strobe
   output logic      [7:0]       regRdData,      // Read data, cycle after strobe
   input  wire logic             globalIrqEn,    // Global interrupt flag
   input  wire logic [1:0]       bootSizeSel,    // Boot size fuse field, pins
   input  wire logic             storeReq,       // Store-program operation
   input  wire logic             loadReq,        // Load-program operation
   input  wire logic [PTR_W-1:0] pointer,        // Pointer register
   input  wire logic [7:0]       lowData,        // Low data register
   input  wire logic [7:0]       highData,       // High data register
   input  wire logic [15:0]      flashWord,      // Flash word at pointer
   input  wire logic [7:0]       sigByte,        // Signature row byte at pointer
   input  wire logic [7:0]       lockByte,       // Lock byte
   input  wire logic [7:0]       fuseByte,       // Fuse byte
   output logic      [7:0]       loadData,       // Load result
   output logic                  loadValid,      // Load result pulse
   output logic                  loadBlocked,    // Load refused, region busy
   output logic                  irqReq,         // Ready interrupt request
   output logic                  cpuHalt,        // Stall the CPU
   output logic                  sectionBusy,    // Region read block
   output logic [PC_W-1:0]       bootResetAddr,  // Boot section start
   output logic                  flashErase,     // Page erase start pulse
   output logic                  flashWrite,     // Page write start pulse
   output logic [PAGE_W-1:0]     flashPage,      // Page being programmed
   input  wire logic             flashDone,      // Flash operation finished
   output logic                  lockWrite,      // Lock program pulse
   output logic [7:0]            lockWrData,     // Lock value
   input  wire logic [6:0]       bufRdIdx,       // Flash reads buffer word
   output logic [15:0]           bufRdData       // Buffer word, one cycle later
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   bspc_state_type           state_q;
   logic [7:0]               csr_q;
   logic [1:0]               bootMeta_q;
   logic [1:0]               bootSync_q;
   logic [PAGE_WORDS-1:0]    bufValid_q;
   logic [15:0]              bufRaw;
   logic [6:0]               bufRdIdx_q;
   logic                     csrWr;
   logic                     legalWr;
   logic                     storeOpen;
   logic                     loadOpen;
   logic                     storeTake;
   logic                     loadTake;
   logic                     startProg;
   logic                     windowEnd;
   logic                     fillTake;
   logic [PAGE_W-1:0]        ptrPage;
   logic [WORD_IDX_W-1:0]    ptrWord;
   logic                     ptrHalting;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   assign csrWr      = regWr && (regAddr == CSR_ADDR);
   assign legalWr    = (regWrData[4:0] == PAT_REEN) || (regWrData[4:0] == PAT_LOCK)   // [R20]
                    || (regWrData[4:0] == PAT_PGWR) || (regWrData[4:0] == PAT_PGER)
                    || (regWrData[4:0] == PAT_FILL);
   assign ptrPage    = pointer[16:8];                                                 // [R4]
   assign ptrWord    = pointer[7:1];                                                  // [R5] [R18]
   assign ptrHalting = (ptrPage >= HALT_PAGE);                                        // [R2] [R17]
   assign storeTake  = storeReq && storeOpen && (state_q == BSPC_ARMED);
   assign loadTake   = loadReq && loadOpen && (state_q == BSPC_ARMED);
   assign startProg  = storeTake && (csr_q[BIT_PGWR] || csr_q[BIT_PGER]);
   assign fillTake   = storeTake && (csr_q[4:0] == PAT_FILL) && !csr_q[BIT_SIG];
   assign windowEnd  = (state_q == BSPC_ARMED) && !storeOpen && !loadOpen;

   ////////////////////////////////////////////////////////////////////////////
   // Command windows, opened by an accepted write
   bspc_window_timer #(.COUNT(STORE_WINDOW)) u_storeWin (
      .clock  (clock),
      .rst    (rst),
      .start  (csrWr && legalWr && state_q != BSPC_BUSY),  // [R22]
      .cancel (storeTake),
      .isOpen (storeOpen)
   );

   bspc_window_timer #(.COUNT(LOAD_WINDOW)) u_loadWin (
      .clock  (clock),
      .rst    (rst),
      .start  (csrWr && legalWr && state_q != BSPC_BUSY),  // [R22]
      .cancel (storeTake),
      .isOpen (loadOpen)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= BSPC_IDLE;
      end else begin
         case (state_q)
            BSPC_IDLE: begin
               if (csrWr && legalWr) state_q <= BSPC_ARMED;
            end
            BSPC_ARMED: begin
               if (startProg) begin
                  state_q <= BSPC_BUSY;                      // [R19]
               end else if ((storeTake || windowEnd) && !(csrWr && legalWr)) begin
                  state_q <= BSPC_IDLE;                      // A fresh write keeps it armed
               end
            end
            BSPC_BUSY: begin
               if (flashDone) state_q <= BSPC_IDLE;
            end
            default: state_q <= BSPC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register; busy bit is owned by hardware
   always_ff @(posedge clock) begin
      if (rst) begin
         csr_q <= CSR_RESET;
      end else begin
         if (csrWr) begin
            csr_q[BIT_IE] <= regWrData[BIT_IE];
         end
         if (csrWr && legalWr && state_q != BSPC_BUSY) begin  // [R20] [R11]
            csr_q[BIT_SIG] <= regWrData[BIT_SIG] && (regWrData[4:0] == PAT_FILL);
            csr_q[4:0]     <= regWrData[4:0];
         end else if ((state_q == BSPC_ARMED && ((storeTake && !startProg) || windowEnd))
                   || (state_q == BSPC_BUSY && flashDone)) begin
            csr_q[BIT_SIG] <= 1'b0;                            // [R13] [R15] [R16] [R19]
            csr_q[4:0]     <= 5'h00;
         end
         // Set wins over any clear in the same cycle
         if (startProg && !ptrHalting) begin
            csr_q[BIT_BUSY] <= 1'b1;                           // [R8]
         end else if (storeTake && csr_q[BIT_REEN]) begin
            csr_q[BIT_BUSY] <= 1'b0;                           // [R9] [R11]
         end else if (fillTake) begin
            csr_q[BIT_BUSY] <= 1'b0;                           // [R9]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port
   always_ff @(posedge clock) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regRd && regAddr == CSR_ADDR) begin
         regRdData <= csr_q;
      end else begin
         regRdData <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash start pulses and page register
   always_ff @(posedge clock) begin
      if (rst) begin
         flashErase <= 1'b0;
         flashWrite <= 1'b0;
         flashPage  <= '0;
      end else begin
         flashErase <= startProg && csr_q[BIT_PGER];           // [R16]
         flashWrite <= startProg && csr_q[BIT_PGWR];           // [R15]
         if (startProg) flashPage <= ptrPage;                  // [R4]
      end
   end

   // Stall the CPU through a halting-region operation
   always_ff @(posedge clock) begin
      if (rst) begin
         cpuHalt <= 1'b0;
      end else if (startProg && ptrHalting) begin
         cpuHalt <= 1'b1;                                      // [R17]
      end else if (state_q == BSPC_BUSY && flashDone) begin
         cpuHalt <= 1'b0;
      end
   end

   // Lock programming from the low data register only
   always_ff @(posedge clock) begin
      if (rst) begin
         lockWrite  <= 1'b0;
         lockWrData <= 8'h00;
      end else begin
         lockWrite <= storeTake && csr_q[BIT_LOCK];            // [R13]
         if (storeTake && csr_q[BIT_LOCK]) lockWrData <= lowData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temporary buffer fill and discard
   bspc_page_buffer #(.DEPTH(PAGE_WORDS), .WIDTH(16)) u_buf (
      .clock  (clock),
      .wrEn   (fillTake),                                      // [R18]
      .wrIdx  (ptrWord),                                       // [R5]
      .wrData ({highData, lowData}),
      .rdIdx  (bufRdIdx),
      .rdData (bufRaw)
   );

   always_ff @(posedge clock) begin
      if (rst) begin
         bufValid_q <= '0;
      end else if (fillTake) begin
         bufValid_q[ptrWord] <= 1'b1;
      end else if (csrWr && legalWr && regWrData[BIT_REEN] && state_q != BSPC_BUSY) begin
         bufValid_q <= '0;                                     // [R12]
      end else if (state_q == BSPC_BUSY && flashDone && csr_q[BIT_PGWR]) begin
         bufValid_q <= '0;                                     // Written page consumes the buffer
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bufRdIdx_q <= '0;
      end else begin
         bufRdIdx_q <= bufRdIdx;
      end
   end

   // Discarded words read as erased
   assign bufRdData = bufValid_q[bufRdIdx_q] ? bufRaw : ERASED_WORD;

   ////////////////////////////////////////////////////////////////////////////
   // Load-program answers
   always_ff @(posedge clock) begin
      if (rst) begin
         loadData    <= 8'h00;
         loadValid   <= 1'b0;
         loadBlocked <= 1'b0;
      end else begin
         loadValid   <= 1'b0;
         loadBlocked <= 1'b0;
         if (loadTake && csr_q[BIT_SIG]) begin
            loadData  <= sigByte;                              // [R10]
            loadValid <= 1'b1;
         end else if (loadTake && csr_q[BIT_LOCK]) begin
            loadData  <= pointer[0] ? fuseByte : lockByte;     // [R14]
            loadValid <= 1'b1;
         end else if (loadReq && csr_q[BIT_BUSY] && !ptrHalting) begin
            loadBlocked <= 1'b1;                               // [R8]
         end else if (loadReq) begin
            loadData  <= pointer[0] ? flashWord[15:8] : flashWord[7:0];  // [R6]
            loadValid <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt request and region flag
   always_ff @(posedge clock) begin
      if (rst) begin
         irqReq      <= 1'b0;
         sectionBusy <= 1'b0;
      end else begin
         irqReq      <= csr_q[BIT_IE] && globalIrqEn && !csr_q[BIT_EN];  // [R7]
         sectionBusy <= csr_q[BIT_BUSY];                                 // [R8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Boot size fuse: two-stage synchroniser, then section start
   always_ff @(posedge clock) begin
      if (rst) begin
         bootMeta_q    <= 2'b00;
         bootSync_q    <= 2'b00;
         bootResetAddr <= '0;
      end else begin
         bootMeta_q    <= bootSizeSel;
         bootSync_q    <= bootMeta_q;
         bootResetAddr <= PC_W'(FLASH_TOP - {1'b0, BOOT_MIN_WORDS << (2'd3 - bootSync_q)});  // [R1] [R3]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_IRQ_LEVEL: assert property (irqReq == $past(csr_q[BIT_IE] && globalIrqEn && !csr_q[BIT_EN]))  // [R7]
      else $error("ready interrupt request wrong");
   AST_BUSY_SET: assert property (startProg && !ptrHalting |=> csr_q[BIT_BUSY] ##1 sectionBusy)  // [R8]
      else $error("busy flag not set on region program");
   AST_FILL_CLEARS: assert property (fillTake && !startProg |=> !csr_q[BIT_BUSY])  // [R9]
      else $error("busy flag not cleared by fill");
   AST_SIG_NOSTORE: assert property (storeTake && csr_q[BIT_SIG] |=> !flashErase && !flashWrite && !lockWrite)  // [R10]
      else $error("store acted in signature window");
   AST_STORE_WINDOW: assert property (csrWr && legalWr && state_q == BSPC_IDLE ##1 (!storeReq && !csrWr) [*4]
                                      ##1 !csrWr |=> state_q == BSPC_IDLE && !csr_q[BIT_EN])  // [R19] [R22]
      else $error("store window did not close after four cycles");
   AST_HALT: assert property (startProg && ptrHalting |=> cpuHalt throughout (state_q == BSPC_BUSY)[*1])  // [R17]
      else $error("cpu not halted for halting page");
   AST_EN_HELD: assert property (state_q == BSPC_BUSY && !flashDone |=> csr_q[BIT_EN])  // [R19]
      else $error("store enable dropped during operation");
   AST_ILLEGAL: assert property (csrWr && !legalWr && state_q == BSPC_IDLE |=> csr_q[4:0] == 5'h00)  // [R20]
      else $error("illegal pattern changed the command bits");
   AST_LOCK_DATA: assert property (storeTake && csr_q[BIT_LOCK] |=> lockWrite && lockWrData == $past(lowData))  // [R13]
      else $error("lock value not taken from low data");
   AST_PAGE: assert property (flashErase || flashWrite |-> flashPage == $past(pointer[16:8]))  // [R4] [R15] [R16]
      else $error("wrong page number");
endmodule

// >>> rtl/bspc_window_timer.sv
// Countdown that keeps a command window open for a fixed number of cycles
`timescale 1ns/1ps
module bspc_window_timer #(
   parameter int COUNT = 4
) (
   input  wire logic clock,   // System clock
   input  wire logic rst,     // Synchronous reset
   input  wire logic start,   // Open the window from the next cycle
   input  wire logic cancel,  // Close the window from the next cycle
   output logic      isOpen   // Window open
);
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] count_q;

   // Refuse a window that could never open
   if (COUNT < 1) $error("window count must be at least one");

   // Load on start, clear on cancel, count down to zero otherwise
   always_ff @(posedge clock) begin
      if (rst) begin
         count_q <= '0;
      end else if (start) begin
         count_q <= CW'(COUNT);
      end else if (cancel) begin
         count_q <= '0;
      end else if (count_q != '0) begin
         count_q <= count_q - CW'(1);
      end
   end

   assign isOpen = (count_q != '0);
endmodule

// >>> sim/bspc_flash_model.sv
// Flash and fuse side model: answers program pulses and load lookups
`timescale 1ns/1ps
module bspc_flash_model #(
   parameter int         DELAY = 12,     // Busy cycles per operation
   parameter logic [7:0] LOCKV = 8'hC3,  // Lock byte, arbitrary
   parameter logic [7:0] FUSEV = 8'h5A   // Fuse byte, arbitrary
) (
   input  wire logic        clock,       // System clock
   input  wire logic        rst,         // Synchronous reset
   input  wire logic [16:0] pointer,     // Pointer register
   input  wire logic        flashErase,  // Erase start
   input  wire logic        flashWrite,  // Write start
   output logic             flashDone,   // Operation finished
   output logic      [15:0] flashWord,   // Word at pointer
   output logic      [7:0]  sigByte,     // Signature byte
   output logic      [7:0]  lockByte,    // Lock byte
   output logic      [7:0]  fuseByte     // Fuse byte
);
   int busyCnt_q;
   ////////////////////////////////////////////////////////////////////////////
   // Flash stays busy for the whole operation, done pulses once at its end
   always_ff @(posedge clock) begin
      if (rst) begin
         busyCnt_q <= 0;
         flashDone <= 1'b0;
      end else begin
         flashDone <= (busyCnt_q == 1);
         if (flashErase || flashWrite) begin
            busyCnt_q <= DELAY;
         end else if (busyCnt_q != 0) begin
            busyCnt_q <= busyCnt_q - 1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Array contents follow the pointer
   assign flashWord = ~pointer[16:1];
   assign sigByte   = pointer[7:0] ^ 8'hA5;
   assign lockByte  = LOCKV;
   assign fuseByte  = FUSEV;
endmodule

// >>> sim/bspc_top_tb.sv
// Self-checking bench for the boot self-program controller
`timescale 1ns/1ps
module bspc_top_tb
   import bspc_pkg::*;
;
   localparam logic [7:0] BAD [4] = '{8'h07, 8'h1F, 8'h15, 8'h0B};
   logic             clock = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, rdSeen_q = 1'b0;
   logic             globalIrqEn = 1'b0, storeReq = 1'b0, loadReq = 1'b0;
   logic [7:0]       regAddr = 8'h00, regWrData = 8'h00, lowData = 8'h00, highData = 8'h00, b;
   logic [1:0]       bootSizeSel = 2'h0;
   logic [PTR_W-1:0] pointer = '0;
   logic [6:0]       bufRdIdx = 7'h00, idx;
   logic [7:0]       regRdData, loadData, lockWrData, sigByte, lockByte, fuseByte;
   logic [15:0]      flashWord, bufRdData, bootResetAddr, w;
   logic [8:0]       flashPage, pg;
   logic             loadValid, loadBlocked, irqReq, cpuHalt, sectionBusy, flashErase, flashWrite, flashDone, lockWrite;
   logic [15:0]      notes [$];
   int               failures = 0, samples_checked = 0, i, mode;
   always #5 clock = ~clock;
   bspc_top u_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .globalIrqEn(globalIrqEn), .bootSizeSel(bootSizeSel), .storeReq(storeReq),
      .loadReq(loadReq), .pointer(pointer), .lowData(lowData), .highData(highData), .flashWord(flashWord),
      .sigByte(sigByte), .lockByte(lockByte), .fuseByte(fuseByte), .loadData(loadData), .loadValid(loadValid),
      .loadBlocked(loadBlocked), .irqReq(irqReq), .cpuHalt(cpuHalt), .sectionBusy(sectionBusy),
      .bootResetAddr(bootResetAddr), .flashErase(flashErase), .flashWrite(flashWrite), .flashPage(flashPage),
      .flashDone(flashDone), .lockWrite(lockWrite), .lockWrData(lockWrData), .bufRdIdx(bufRdIdx), .bufRdData(bufRdData));
   bspc_flash_model u_flash (.clock(clock), .rst(rst), .pointer(pointer), .flashErase(flashErase),
      .flashWrite(flashWrite), .flashDone(flashDone), .flashWord(flashWord), .sigByte(sigByte),
      .lockByte(lockByte), .fuseByte(fuseByte));
   ////////////////////////////////////////////////////////////////////////////
   // Comparison and bus tasks
   task check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task take(input logic [15:0] got);
      check(got, (notes.size() != 0) ? notes.pop_front() : ~got);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock); regWr <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge clock); regWr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock); regRd <= 1'b1; regAddr <= a; notes.push_back({8'h40, exp});
      @(posedge clock); regRd <= 1'b0;
   endtask
   task st(input logic [16:0] p, input logic [7:0] hi, input logic [7:0] lo);
      @(posedge clock); storeReq <= 1'b1; pointer <= p; highData <= hi; lowData <= lo;
      @(posedge clock); storeReq <= 1'b0; pointer <= ~p; highData <= ~hi; lowData <= ~lo;
   endtask
   task ld(input logic [16:0] p, input logic [15:0] note);
      @(posedge clock); loadReq <= 1'b1; pointer <= p; notes.push_back(note);
      @(posedge clock); loadReq <= 1'b0; pointer <= ~p;
   endtask
   task waitDone;
      for (int k = 0; k < 100 && flashDone !== 1'b1; k++) @(posedge clock);
      repeat (2) @(posedge clock);
   endtask
   task give_verdict;
      if (notes.size() != 0) failures++;
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Result watcher: every answer or pulse consumes the oldest note
   always @(posedge clock) begin
      rdSeen_q <= regRd;
      if (!rst) begin
         if (rdSeen_q) take({8'h40, regRdData});
         if (loadValid) take({8'h10, loadData});
         if (loadBlocked) take(16'h2000);
         if (lockWrite) take({8'h30, lockWrData});
         if (flashErase) take({7'h28, flashPage});
         if (flashWrite) take({7'h30, flashPage});
      end
   end
   // Watchdog sized well past the expected run of under a thousand cycles
   initial begin
      #50000;
      failures++;
      give_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h2E68779F));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         bootSizeSel <= 2'(i);
         repeat (5) @(posedge clock);
         #1 check(bootResetAddr, 16'(32'h10000 - (32'd512 << (3 - i))));
      end
      rd(CSR_ADDR, 8'h00);
      rd(8'h38, 8'h00);
      for (i = 0; i < 4; i++) begin
         idx = 7'($urandom);
         w = 16'($urandom);
         wr(CSR_ADDR, {3'h0, PAT_FILL});
         st({9'h000, idx, 1'b0}, w[15:8], w[7:0]);
         @(posedge clock); bufRdIdx <= idx;
         repeat (2) @(posedge clock);
         #1 check(bufRdData, w);
      end
      wr(CSR_ADDR, 8'h11);
      repeat (4) @(posedge clock);
      #1 check(bufRdData, ERASED_WORD);
      for (mode = 0; mode < 2; mode++) begin
         pg = 9'($urandom % 480);
         wr(CSR_ADDR, {3'h0, PAT_PGER});
         repeat (2 * mode) @(posedge clock);
         notes.push_back({7'h28, pg});
         st({pg, 8'h00}, 8'h00, 8'h00);
         repeat (3) @(posedge clock);
         #1 check({15'h0, sectionBusy}, 16'h0001);
         ld(17'h01001, 16'h2000);
         ld(17'h1F003, 16'h1007);
         rd(CSR_ADDR, 8'h43);
         wr(CSR_ADDR, 8'h11);
         waitDone;
         rd(CSR_ADDR, 8'h40);
         if (mode == 0) begin
            wr(CSR_ADDR, {3'h0, PAT_FILL});
            st(17'h00002, 8'h12, 8'h34);
         end else begin
            wr(CSR_ADDR, 8'h11);
            st(17'h00000, 8'h00, 8'h00);
         end
         repeat (3) @(posedge clock);
         #1 check({15'h0, sectionBusy}, 16'h0000);
      end
      pg = 9'(480 + $urandom % 32);
      wr(CSR_ADDR, {3'h0, PAT_PGWR});
      notes.push_back({7'h30, pg});
      st({pg, 8'h00}, 8'hAA, 8'h55);
      repeat (3) @(posedge clock);
      #1 check({15'h0, cpuHalt}, 16'h0001);
      check({15'h0, sectionBusy}, 16'h0000);
      waitDone;
      #1 check({15'h0, cpuHalt}, 16'h0000);
      rd(CSR_ADDR, 8'h00);
      b = 8'($urandom);
      wr(CSR_ADDR, {3'h0, PAT_LOCK});
      ld(17'h00001, 16'h105A);
      wr(CSR_ADDR, {3'h0, PAT_LOCK});
      ld(17'h00000, 16'h10C3);
      wr(CSR_ADDR, {3'h0, PAT_LOCK});
      notes.push_back({8'h30, b});
      st(17'h1FFFE, 8'hFF, b);
      rd(CSR_ADDR, 8'h00);
      wr(CSR_ADDR, 8'h21);
      ld(17'h00005, 16'h10A0);
      wr(CSR_ADDR, 8'h21);
      st(17'h01000, 8'h00, 8'h00);
      wr(CSR_ADDR, {3'h0, PAT_PGER});
      repeat (3) @(posedge clock);
      st(17'h00500, 8'h00, 8'h00);
      rd(CSR_ADDR, 8'h00);
      for (i = 0; i < 4; i++) begin
         wr(CSR_ADDR, BAD[i]);
         rd(CSR_ADDR, 8'h00);
      end
      globalIrqEn <= 1'b1;
      wr(CSR_ADDR, 8'h80);
      repeat (2) @(posedge clock);
      #1 check({15'h0, irqReq}, 16'h0001);
      rd(CSR_ADDR, 8'h80);
      globalIrqEn <= 1'b0;
      repeat (2) @(posedge clock);
      #1 check({15'h0, irqReq}, 16'h0000);
      globalIrqEn <= 1'b1;
      wr(CSR_ADDR, 8'h81);
      @(posedge clock);
      #1 check({15'h0, irqReq}, 16'h0000);
      repeat (8) @(posedge clock);
      give_verdict;
   end
endmodule
